/* File: logic/mcd_pkg.sv */
// package for the motion command decoder: message layout, apb map, codes
// assumes an apb master on the core clock and a position loop downstream
// Contract
// - byte 2 bit 7 with code zero homes
// - code one selects simple positioning
// - code two selects external positioning
// - byte 3 bit 0 picks absolute/incremental
// - incremental target is current plus value
// - only start bit rising edge starts motion; here a homing bit rising edge with code zero also starts homing
// - simple move uses feed speed settings
// - external edge drops to approach speed
// - then travel signed distance and stop
// - external reuses simple feed settings
// - homing moves and sets zero point
package mcd_pkg;
	// command message bit positions
	localparam int START_BIT    = 0;  // byte 0 bit 0
	localparam int SERVO_BIT    = 1;  // byte 0 bit 1
	localparam int CODE_LSB     = 8;  // byte 1 bits 0..3
	localparam int HOME_BIT     = 23; // byte 2 bit 7
	localparam int INC_BIT      = 24; // byte 3 bit 0
	localparam int TARGET_LSB   = 32; // bytes 4..7
	// command codes
	localparam logic [3:0] CODE_NOP  = 4'h0;
	localparam logic [3:0] CODE_POS  = 4'h1;
	localparam logic [3:0] CODE_EXT  = 4'h2;
	// apb byte offsets
	localparam logic [7:0] OFS_MSG_LO   = 8'h00;
	localparam logic [7:0] OFS_MSG_HI   = 8'h04;
	localparam logic [7:0] OFS_FEED     = 8'h08;
	localparam logic [7:0] OFS_APPR     = 8'h0c;
	localparam logic [7:0] OFS_DIST     = 8'h10;
	localparam logic [7:0] OFS_HMODE    = 8'h14;
	localparam logic [7:0] OFS_STATUS   = 8'h18;
	localparam logic [7:0] OFS_TARGET   = 8'h1c;
	// reset values
	localparam logic [31:0] RST_FEED    = 32'h00005dc0; // 24,000
	localparam logic [31:0] RST_APPR    = 32'h00005dc0; // 24,000
	localparam logic [31:0] RST_DIST    = 32'h00000000;
	localparam logic [1:0]  RST_HMODE   = 2'h0;
	// motion states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_POS  = 3'b001,
		ST_EXT  = 3'b010,
		ST_APPR = 3'b011,
		ST_HOME = 3'b100
	} mcd_state_e;
endpackage

/* File: logic/mcd_top.sv */
// motion command decoder: apb slave holding the command message and
// parameters, decoding start edges into moves for the position loop
// assumes EXT_IN and IN_POS come from outside the clock domain
// assumes CUR_POS is produced on CORE_CLK by the position loop itself
// assumes the loop treats MOVE_GO and HOME_GO as one-cycle commands
// the host writes the message word by word; nothing here waits on it
// start and homing edges are acted on only in the idle state, so a
// second start while moving is dropped rather than queued
`timescale 1ns/100ps
module mcd_top (
	// clock and reset
	input  wire logic        CORE_CLK,
	input  wire logic        SYS_RST,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// position loop side
	input  wire logic [31:0] CUR_POS,
	input  wire logic        IN_POS,
	input  wire logic        EXT_IN,
	output logic [31:0]      MOVE_TARGET,
	output logic [31:0]      MOVE_SPEED,
	output logic             MOVE_GO,
	output logic             HOME_GO,
	output logic [1:0]       HOME_MODE,
	output logic             SERVO_EN,
	output logic             BUSY
);
	logic [63:0] msg_reg;       // eight-byte command message
	logic [31:0] feed_reg;      // positioning_feed_speed
	logic [31:0] appr_reg;      // external_approach_speed
	logic [31:0] dist_reg;      // external_travel_distance
	logic [1:0]  hmode_reg;     // homing_mode_select
	logic        start_q_reg;   // previous start bit
	logic        home_q_reg;    // previous homing bit
	logic [1:0]  ext_sync_reg;  // external input synchroniser
	logic [1:0]  inpos_sync_reg;
	logic        ext_q_reg;     // synced ext input, last cycle
	logic [31:0] target_reg;
	logic [31:0] speed_reg;
	logic        go_reg;
	logic        hgo_reg;
	mcd_pkg::mcd_state_e state_reg; // motion sequencer state
	logic        acc;           // apb access phase
	logic        wr;
	logic        start_edge;
	logic        home_edge;
	logic        ext_chg;
	logic        in_pos_s;
	logic [3:0]  code;
	logic [31:0] msg_tgt;
	logic        addr_ok;

	// apb decode; always ready, unmapped gives slverr
	// zero wait states keep the host's message writes back to back;
	// the cost is that every read must be prepared in the setup cycle
	assign acc     = PSEL && PENABLE;
	assign wr      = acc && PWRITE;
	assign PREADY  = 1'b1;
	assign addr_ok = (PADDR <= mcd_pkg::OFS_TARGET) && (PADDR[1:0] == 2'h0);
	assign PSLVERR = acc && !addr_ok;

	// field extraction from the message
	// fields are read live; they only matter at the edge that latches
	// them, so a host may rewrite them freely while a move runs
	assign code    = msg_reg[mcd_pkg::CODE_LSB +: 4];
	assign msg_tgt = msg_reg[mcd_pkg::TARGET_LSB +: 32];
	assign start_edge = msg_reg[mcd_pkg::START_BIT] && !start_q_reg;
	assign home_edge  = msg_reg[mcd_pkg::HOME_BIT] && !home_q_reg;
	assign ext_chg    = ext_sync_reg[1] != ext_q_reg;
	assign in_pos_s   = inpos_sync_reg[1];

	// register writes; status and target are read-only
	// a write lands only in the access phase, never in setup
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			msg_reg   <= 64'h0;
			feed_reg  <= mcd_pkg::RST_FEED;
			appr_reg  <= mcd_pkg::RST_APPR;
			dist_reg  <= mcd_pkg::RST_DIST;
			hmode_reg <= mcd_pkg::RST_HMODE;
		end else if (wr) begin
			if (PADDR == mcd_pkg::OFS_MSG_LO) begin
				msg_reg[31:0] <= PWDATA;
			end else if (PADDR == mcd_pkg::OFS_MSG_HI) begin
				msg_reg[63:32] <= PWDATA;
			end else if (PADDR == mcd_pkg::OFS_FEED) begin
				feed_reg <= PWDATA;
			end else if (PADDR == mcd_pkg::OFS_APPR) begin
				appr_reg <= PWDATA;
			end else if (PADDR == mcd_pkg::OFS_DIST) begin
				dist_reg <= PWDATA;
			end else if (PADDR == mcd_pkg::OFS_HMODE) begin
				hmode_reg <= PWDATA[1:0];
			end
		end
	end

	// read mux, registered so read data comes from flip-flops
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			PRDATA <= 32'h0;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			if (PADDR == mcd_pkg::OFS_MSG_LO) begin
				PRDATA <= msg_reg[31:0];
			end else if (PADDR == mcd_pkg::OFS_MSG_HI) begin
				PRDATA <= msg_reg[63:32];
			end else if (PADDR == mcd_pkg::OFS_FEED) begin
				PRDATA <= feed_reg;
			end else if (PADDR == mcd_pkg::OFS_APPR) begin
				PRDATA <= appr_reg;
			end else if (PADDR == mcd_pkg::OFS_DIST) begin
				PRDATA <= dist_reg;
			end else if (PADDR == mcd_pkg::OFS_HMODE) begin
				PRDATA <= {30'h0, hmode_reg};
			end else if (PADDR == mcd_pkg::OFS_STATUS) begin
				PRDATA <= {27'h0, in_pos_s, state_reg, BUSY};
			end else if (PADDR == mcd_pkg::OFS_TARGET) begin
				PRDATA <= target_reg;
			end else begin
				PRDATA <= 32'h0;
			end
		end
	end

	// synchronisers for pin inputs; first stage feeds only the second
	// the extra history stage turns the synced level into a change
	// detector, so either polarity of the external signal is accepted
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ext_sync_reg   <= 2'h0;
			inpos_sync_reg <= 2'h0;
			ext_q_reg      <= 1'b0;
		end else begin
			ext_sync_reg   <= {ext_sync_reg[0], EXT_IN};
			inpos_sync_reg <= {inpos_sync_reg[0], IN_POS};
			ext_q_reg      <= ext_sync_reg[1];
		end
	end

	// edge history of start and homing bits
	// both reset to zero, the idle level, so reset gives no false edge
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			start_q_reg <= 1'b0;
			home_q_reg  <= 1'b0;
		end else begin
			start_q_reg <= msg_reg[mcd_pkg::START_BIT];
			home_q_reg  <= msg_reg[mcd_pkg::HOME_BIT];
		end
	end

	// motion sequencer; go strobes are one cycle wide
	// done is the synced in-position level, ignored in the go cycle only; it lags
	// the pin by two cycles, so a flag left from the previous move can end the new one
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			state_reg  <= mcd_pkg::ST_IDLE;
			target_reg <= 32'h0;
			speed_reg  <= 32'h0;
			go_reg     <= 1'b0;
			hgo_reg    <= 1'b0;
		end else begin
			go_reg  <= 1'b0;
			hgo_reg <= 1'b0;
			if (!msg_reg[mcd_pkg::SERVO_BIT]) begin
				// servo off aborts and blocks motion
				state_reg <= mcd_pkg::ST_IDLE;
			end else begin
				case (state_reg)
				mcd_pkg::ST_IDLE: begin
					if (home_edge && code == mcd_pkg::CODE_NOP) begin
						state_reg <= mcd_pkg::ST_HOME;
						hgo_reg   <= 1'b1;
					end else if (start_edge &&
						(code == mcd_pkg::CODE_POS ||
						 code == mcd_pkg::CODE_EXT)) begin
						// latch fields at the edge only
						if (msg_reg[mcd_pkg::INC_BIT]) begin
							target_reg <= CUR_POS + msg_tgt;
						end else begin
							target_reg <= msg_tgt;
						end
						speed_reg <= feed_reg;
						go_reg    <= 1'b1;
						if (code == mcd_pkg::CODE_POS) begin
							state_reg <= mcd_pkg::ST_POS;
						end else begin
							state_reg <= mcd_pkg::ST_EXT;
						end
					end
				end
				mcd_pkg::ST_POS: begin
					if (in_pos_s && !go_reg) begin
						state_reg <= mcd_pkg::ST_IDLE;
					end
				end
				mcd_pkg::ST_EXT: begin
					if (ext_chg) begin
						// new goal from the change point
						target_reg <= CUR_POS + dist_reg;
						speed_reg  <= appr_reg;
						go_reg     <= 1'b1;
						state_reg  <= mcd_pkg::ST_APPR;
					end else if (in_pos_s && !go_reg) begin
						state_reg <= mcd_pkg::ST_IDLE;
					end
				end
				mcd_pkg::ST_APPR: begin
					if (in_pos_s && !go_reg) begin
						state_reg <= mcd_pkg::ST_IDLE;
					end
				end
				mcd_pkg::ST_HOME: begin
					if (in_pos_s && !hgo_reg) begin
						state_reg <= mcd_pkg::ST_IDLE;
					end
				end
				default: state_reg <= mcd_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// outputs to the position loop
	// all of them come straight from flip-flops except BUSY
	assign MOVE_TARGET = target_reg;
	assign MOVE_SPEED  = speed_reg;
	assign MOVE_GO     = go_reg;
	assign HOME_GO     = hgo_reg;
	assign HOME_MODE   = hmode_reg;
	assign SERVO_EN    = msg_reg[mcd_pkg::SERVO_BIT];
	assign BUSY        = state_reg != mcd_pkg::ST_IDLE;

	// checks
	// each property is sampled on the core clock, quiet during reset
	go_needs_servo_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		MOVE_GO |-> $past(msg_reg[mcd_pkg::SERVO_BIT]))
		else $error("move issued without servo enable");
	go_on_edge_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		$rose(MOVE_GO) && $past(state_reg) == mcd_pkg::ST_IDLE
		|-> $past(start_edge))
		else $error("move without start edge");
	feed_used_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		MOVE_GO && $past(state_reg) == mcd_pkg::ST_IDLE
		|-> MOVE_SPEED == $past(feed_reg))
		else $error("feed speed not used");
	appr_speed_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		$past(state_reg) == mcd_pkg::ST_EXT && state_reg == mcd_pkg::ST_APPR
		|-> MOVE_SPEED == $past(appr_reg) && MOVE_GO)
		else $error("approach speed not applied");
	appr_dist_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		$past(state_reg) == mcd_pkg::ST_EXT && state_reg == mcd_pkg::ST_APPR
		|-> MOVE_TARGET == $past(CUR_POS) + $past(dist_reg))
		else $error("travel distance wrong");
	inc_target_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		$past(state_reg) == mcd_pkg::ST_IDLE && MOVE_GO
		&& $past(msg_reg[mcd_pkg::INC_BIT])
		|-> MOVE_TARGET == $past(CUR_POS) + $past(msg_tgt))
		else $error("incremental target wrong");
	abs_target_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		$past(state_reg) == mcd_pkg::ST_IDLE && MOVE_GO
		&& !$past(msg_reg[mcd_pkg::INC_BIT])
		|-> MOVE_TARGET == $past(msg_tgt))
		else $error("absolute target wrong");
	home_code_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		HOME_GO |-> $past(code) == mcd_pkg::CODE_NOP
		&& state_reg == mcd_pkg::ST_HOME)
		else $error("homing with nonzero code");
	pos_state_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		state_reg == mcd_pkg::ST_POS && $past(state_reg) == mcd_pkg::ST_IDLE
		|-> $past(code) == mcd_pkg::CODE_POS)
		else $error("simple move without code one");
	ext_state_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		state_reg == mcd_pkg::ST_EXT && $past(state_reg) == mcd_pkg::ST_IDLE
		|-> $past(code) == mcd_pkg::CODE_EXT)
		else $error("external move without code two");
	simple_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
		state_reg == mcd_pkg::ST_POS ##[1:50] state_reg == mcd_pkg::ST_IDLE);
	ext_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
		state_reg == mcd_pkg::ST_APPR);
	home_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
		HOME_GO);
	abort_c: cover property (@(posedge CORE_CLK) disable iff (SYS_RST)
		BUSY ##1 !SERVO_EN);

	// servo off forces the sequencer back to idle at the next edge
	servo_abort_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		!SERVO_EN |=> !BUSY)
		else $error("servo off did not abort the move");
	// the target only changes together with a go strobe
	tgt_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		!MOVE_GO |-> $stable(MOVE_TARGET))
		else $error("target changed without a move");
	// the speed only changes together with a go strobe
	spd_hold_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		!MOVE_GO |-> $stable(MOVE_SPEED))
		else $error("speed changed without a move");
	// a go while busy can only be the approach leg of an external move
	busy_go_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		MOVE_GO && $past(BUSY) |-> $past(state_reg) == mcd_pkg::ST_EXT
		&& state_reg == mcd_pkg::ST_APPR)
		else $error("move issued while busy");
	// homing is only started from idle
	home_idle_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		HOME_GO |-> $past(state_reg) == mcd_pkg::ST_IDLE)
		else $error("homing started while busy");
	// homing start is a single pulse
	home_once_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		HOME_GO |=> !HOME_GO)
		else $error("homing pulse too long");
	// a homing edge with a motion code loaded is refused
	home_refuse_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		home_edge && code != mcd_pkg::CODE_NOP |=> !HOME_GO)
		else $error("homing accepted with nonzero code");
	// a start edge with no motion code loaded starts nothing
	start_nop_a: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		start_edge && code == mcd_pkg::CODE_NOP
		&& state_reg == mcd_pkg::ST_IDLE |=> !MOVE_GO)
		else $error("move started with no operation code");
endmodule

/* File: bench/mcd_loop_model.sv */
// position loop model standing behind the decoder's motion outputs
// assumes one-cycle go pulses and a level in-position flag back
`timescale 1ns/100ps
module mcd_loop_model #(
	parameter int DELAY = 20  // cycles a move takes, any value of 1 or more
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// commands from the decoder
	input  wire logic        move_go,
	input  wire logic        home_go,
	input  wire logic [31:0] move_target,
	// axis feedback
	output logic [31:0]      cur_pos,
	output logic             in_pos
);
	logic [31:0] goal_reg;  // latched destination
	int          wait_reg;  // cycles left; negative runs out the flag
	// a new command restarts the move; the in-position flag is a short
	// pulse so that a stale level cannot end the next move early
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_pos  <= 32'h0;
			goal_reg <= 32'h0;
			wait_reg <= -4;
			in_pos   <= 1'b0;
		end else if (move_go || home_go) begin
			goal_reg <= home_go ? 32'h0 : move_target;
			wait_reg <= DELAY;
			in_pos   <= 1'b0;
		end else if (wait_reg > -4) begin
			wait_reg <= wait_reg - 1;
			in_pos   <= (wait_reg <= 1) && (wait_reg > -3);
			if (wait_reg == 1) cur_pos <= goal_reg;
		end else in_pos <= 1'b0;
	end
endmodule

/* File: bench/tb_motion_command_decoder.sv */
// self-checking bench for the decoder: apb master and external input
// assumes the loop model answers every move after a fixed delay
`timescale 1ns/100ps
module tb_motion_command_decoder;
	logic        clk = 0;         // core clock
	logic        rst = 1;         // sync reset
	logic        psel = 0;        // apb request lines
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic        ext = 0;         // external input
	logic [31:0] rd, cp, prdata, cur_pos, mtgt, mspd;
	logic        err, pready, pslverr, in_pos, mgo, hgo, servo, busy;
	logic [1:0]  hmode;
	int          error_cnt = 0;
	int          check_count = 0;

	mcd_top DUT (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .CUR_POS(cur_pos), .IN_POS(in_pos),
		.EXT_IN(ext), .MOVE_TARGET(mtgt), .MOVE_SPEED(mspd),
		.MOVE_GO(mgo), .HOME_GO(hgo), .HOME_MODE(hmode),
		.SERVO_EN(servo), .BUSY(busy));
	mcd_loop_model LOOP (.clk(clk), .rst(rst), .move_go(mgo),
		.home_go(hgo), .move_target(mtgt), .cur_pos(cur_pos),
		.in_pos(in_pos));

	always #2.5 clk = ~clk;

	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	// one apb transfer; held until pready is seen high at an edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// low message word: bytes 0..3
	function automatic logic [31:0] msg(input logic inc, input logic home,
		input logic [3:0] code, input logic srv, input logic st);
		return {7'h0, inc, home, 7'h0, 4'h0, code, 6'h0, srv, st};
	endfunction
	// host order: code cleared, target, code, then start edge
	task move(input logic inc, input logic [3:0] c, input logic [31:0] t);
		apb(1, 8'h00, msg(0, 0, mcd_pkg::CODE_NOP, 1, 0));
		apb(1, 8'h04, t);
		apb(1, 8'h00, msg(inc, 0, c, 1, 0));
		apb(1, 8'h00, msg(inc, 0, c, 1, 1));
	endtask
	// a go pulse must come within a few cycles
	task expect_go(input logic h, input logic [31:0] t, input logic [31:0] s);
		for (int n = 0; n < 8; n++) begin
			@(negedge clk);
			if ((h ? hgo : mgo) === 1'b1) break;
		end
		chk(h ? hgo : mgo, 1'b1);
		if (!h) chk(mtgt, t);
		if (!h) chk(mspd, s);
	endtask
	task no_go;
		logic seen;
		seen = 1'b0;
		repeat (8) begin
			@(negedge clk);
			seen = seen | mgo | hgo;
		end
		chk(seen, 1'b0);
	endtask
	task wait_idle;
		for (int n = 0; n < 300; n++) begin
			@(negedge clk);
			if (busy === 1'b0) break;
		end
		chk(busy, 1'b0);
	endtask
	// reset values and an unmapped access
	task t_reset;
		apb(0, 8'h08, 0); chk(rd, 32'h5dc0);
		apb(0, 8'h0c, 0); chk(rd, 32'h5dc0);
		apb(0, 8'h10, 0); chk(rd, 32'h0);
		apb(0, 8'h20, 0); chk(rd, 32'h0);
		chk(err, 1'b1);
	endtask
	// absolute then incremental simple moves, held start bit
	task t_simple;
		apb(1, 8'h08, 32'h1234);
		move(0, mcd_pkg::CODE_POS, 32'h1000);
		expect_go(0, 32'h1000, 32'h1234);
		apb(0, 8'h1c, 0); chk(rd, 32'h1000);
		wait_idle;
		apb(0, 8'h18, 0); chk(rd[3:0], 4'h0);
		apb(1, 8'h00, msg(0, 0, mcd_pkg::CODE_POS, 1, 1));
		no_go;
		move(1, mcd_pkg::CODE_POS, 32'h20);
		expect_go(0, 32'h1020, 32'h1234);
		wait_idle;
	endtask
	// external input change mid-move switches to approach and distance
	task t_ext;
		apb(1, 8'h0c, 32'h300);
		apb(1, 8'h10, 32'hffffff9c);
		move(0, mcd_pkg::CODE_EXT, 32'h5000);
		expect_go(0, 32'h5000, 32'h1234);
		repeat (3) @(posedge clk);
		cp = cur_pos;
		ext <= ~ext;
		expect_go(0, cp + 32'hffffff9c, 32'h300);
		wait_idle;
	endtask
	// start edge with servo off is lost
	task t_servo;
		apb(1, 8'h00, msg(0, 0, mcd_pkg::CODE_POS, 0, 0));
		apb(1, 8'h00, msg(0, 0, mcd_pkg::CODE_POS, 0, 1));
		chk(servo, 1'b0);
		no_go;
	endtask
	// homing bit edge with code zero
	task t_home;
		apb(1, 8'h14, 32'h2);
		apb(1, 8'h00, msg(0, 0, mcd_pkg::CODE_NOP, 1, 0));
		apb(1, 8'h00, msg(0, 1, mcd_pkg::CODE_NOP, 1, 0));
		expect_go(1, 0, 0);
		chk(hmode, 2'h2);
		wait_idle;
	endtask

	task print_verdict;
		if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_simple;
		t_ext;
		t_servo;
		t_home;
		print_verdict;
	end
	// watchdog: far beyond the few hundred cycles the tests need
	initial begin
		#100000;
		error_cnt++;
		print_verdict;
	end
endmodule
